// >>> logic/dchan_setup_map.vh
// register offsets, field positions, reset values and interrupt layout
// assumes apb word addressing: byte address = 4 * printed index
//
// Operation
// - writing 00H to the receive line-decoder config at 10H selects B8ZS decoding.
// - the transmit formatter config at 44H carries 3 in its upper nibble for B8ZS and ESF, low bits pick datalink rate and zero suppression.
// - framer config at 20H takes 1XH, 5XH or 9XH for ESF with 2-of-4, 2-of-5 or 2-of-6 out-of-frame threshold.
// - bit-code enable at 2AH selects 8-of-10 validation with 00H and 4-of-5 with 02H.
// - alarm integrator config at 2CH takes 1XH for ESF, its low bits matching the framer.
// - writing 00H to the in-band detector config at 3CH enables loopback code detection.
// - loopback activate pattern at 3EH may be 08H and deactivate pattern at 3FH 44H.
// - signalling extractor config at 40H takes 1XH for ESF, low bits matching the framer.
// - writing 5FH to datalink options at 02H enables both datalink controllers.
// - with 5FH the datalink request lines become interrupt sources, identified in registers 8 and 9.
// - with that setting the D-channel appears on the receive and transmit datalink serial and clock pins.
`ifndef DCHAN_SETUP_MAP_VH
`define DCHAN_SETUP_MAP_VH
`define IDX_DL_OPTIONS   8'h02
`define IDX_INT_SRC_A    8'h08
`define IDX_INT_SRC_B    8'h09
`define IDX_RX_DEC_CFG   8'h10
`define IDX_FRAMER_CFG   8'h20
`define IDX_BITCODE_EN   8'h2A
`define IDX_ALARM_CFG    8'h2C
`define IDX_INBAND_CFG   8'h3C
`define IDX_LB_ACT       8'h3E
`define IDX_LB_DEACT     8'h3F
`define IDX_SIGNALLING_EXTRACTOR_CFG     8'h40
`define IDX_TX_FMT_CFG   8'h44
`define IDX_INT_STATUS   8'h50
`define IDX_INT_ENABLE   8'h51
`define IDX_INT_CLEAR    8'h52
`define IDX_CFG_STATUS   8'h53
`define RST_REG          8'h00
`define RST_RX_DEC       8'h01
`define DL_DCHAN_VALUE   8'h5F
`define FMT_ESF_B8ZS     4'h3
`define ESF_SEL_BIT      4
`define RATE_MSB         1
`define OOF_LO           6
`define OOF_HI           7
`define BOC_FAST_BIT     1
`define NUM_EV           4
`define SYNC_STAGES      3
`endif

// >>> logic/pin_sync.v
// three-flop synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to pclk
`timescale 1ns/1ps
module pin_sync (
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire pin,
  output reg  level_r
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  // s1 only feeds s2 to keep metastability contained
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else if (ce) begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_r <= s3_r;
      end
    end
  end
endmodule // pin_sync

// >>> logic/dchan_setup.v
// apb register block and d-channel routing of an esf framer setup
// assumes apb master, one clock pclk, external datalink core on pins
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "dchan_setup_map.vh"
module dchan_setup (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_datalink_request,
  input  wire        rx_datalink_end_of_message,
  input  wire        tx_datalink_request,
  input  wire        tx_datalink_underrun,
  input  wire        rx_dl_serial_in,
  input  wire        rx_dl_clock_in,
  output reg         tx_dl_serial_out,
  output reg         rx_dchannel_serial,
  output reg         rx_dchannel_clock,
  input  wire        tx_dchannel_serial,
  output reg         tx_dchannel_clock,
  output reg         dma_req_rx_r,
  output reg         dma_req_tx_r,
  output reg         b8zs_rx_r,
  output reg         b8zs_tx_r,
  output reg         esf_all_r,
  output reg  [1:0]  oof_sel_r,
  output reg         boc_fast_r,
  output reg         inband_en_r,
  output reg         common_interrupt_n
);
  reg  [7:0] dl_options_r;
  reg  [7:0] rx_dec_cfg_r;
  reg  [7:0] framer_cfg_r;
  reg  [7:0] bitcode_en_r;
  reg  [7:0] alarm_cfg_r;
  reg  [7:0] inband_cfg_r;
  reg  [7:0] lb_act_r;
  reg  [7:0] lb_deact_r;
  reg  [7:0] signalling_extractor_cfg_r;
  reg  [7:0] tx_fmt_cfg_r;
  reg  [3:0] int_status_r;
  reg  [3:0] int_enable_r;
  reg  [3:0] ev_prev_r;
  reg  [31:0] rd_nxt;
  reg         err_nxt;
  wire [7:0]  idx;
  wire        wr_en;
  wire        rd_en;
  wire [3:0]  ev_raw;
  wire [3:0]  ev_lvl;
  wire [3:0]  ev_rise;
  wire [3:0]  clr_mask;
  wire        dchan_mode;
  wire        cfg_match;
  wire        rx_ser_s;
  wire        rx_clk_s;
  wire        tx_ser_s;

  assign idx   = paddr[9:2];
  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;
  assign ev_raw = {tx_datalink_underrun, tx_datalink_request,
                   rx_datalink_end_of_message, rx_datalink_request};
  assign dchan_mode = (dl_options_r == `DL_DCHAN_VALUE);

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_EV; gi = gi + 1) begin : g_ev
      pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .pin     (ev_raw[gi]),
        .level_r (ev_lvl[gi])
      );
    end
  endgenerate

  pin_sync u_rxs (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin     (rx_dl_serial_in),
    .level_r (rx_ser_s)
  );
  pin_sync u_rxc (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin     (rx_dl_clock_in),
    .level_r (rx_clk_s)
  );
  pin_sync u_txs (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pin     (tx_dchannel_serial),
    .level_r (tx_ser_s)
  );

  assign ev_rise  = ev_lvl & ~ev_prev_r;
  assign clr_mask = (wr_en && idx == `IDX_INT_CLEAR) ? pwdata[3:0] : 4'h0;
  assign cfg_match = (framer_cfg_r[3:0] == tx_fmt_cfg_r[3:0]) &&
                     (alarm_cfg_r[3:0] == framer_cfg_r[3:0]) &&
                     (signalling_extractor_cfg_r[3:0] == framer_cfg_r[3:0]);

  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (idx == `IDX_DL_OPTIONS) begin
      rd_nxt[7:0] = dl_options_r;
    end else if (idx == `IDX_INT_SRC_A) begin
      rd_nxt[7:0] = {6'h00, int_status_r[1:0]};
    end else if (idx == `IDX_INT_SRC_B) begin
      rd_nxt[7:0] = {6'h00, int_status_r[3:2]};
    end else if (idx == `IDX_RX_DEC_CFG) begin
      rd_nxt[7:0] = rx_dec_cfg_r;
    end else if (idx == `IDX_FRAMER_CFG) begin
      rd_nxt[7:0] = framer_cfg_r;
    end else if (idx == `IDX_BITCODE_EN) begin
      rd_nxt[7:0] = bitcode_en_r;
    end else if (idx == `IDX_ALARM_CFG) begin
      rd_nxt[7:0] = alarm_cfg_r;
    end else if (idx == `IDX_INBAND_CFG) begin
      rd_nxt[7:0] = inband_cfg_r;
    end else if (idx == `IDX_LB_ACT) begin
      rd_nxt[7:0] = lb_act_r;
    end else if (idx == `IDX_LB_DEACT) begin
      rd_nxt[7:0] = lb_deact_r;
    end else if (idx == `IDX_SIGNALLING_EXTRACTOR_CFG) begin
      rd_nxt[7:0] = signalling_extractor_cfg_r;
    end else if (idx == `IDX_TX_FMT_CFG) begin
      rd_nxt[7:0] = tx_fmt_cfg_r;
    end else if (idx == `IDX_INT_STATUS) begin
      rd_nxt[3:0] = int_status_r;
    end else if (idx == `IDX_INT_ENABLE) begin
      rd_nxt[3:0] = int_enable_r;
    end else if (idx == `IDX_INT_CLEAR) begin
      rd_nxt = 32'h0000_0000;
    end else if (idx == `IDX_CFG_STATUS) begin
      rd_nxt[1:0] = {dchan_mode, cfg_match};
    end else begin
      err_nxt = 1'b1;
    end
  end

  // apb: one wait state, answer on the second access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & err_nxt;
      if (rd_en) begin
        prdata <= rd_nxt;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dl_options_r <= `RST_REG;
      rx_dec_cfg_r <= `RST_RX_DEC;
      framer_cfg_r <= `RST_REG;
      bitcode_en_r <= `RST_REG;
      alarm_cfg_r  <= `RST_REG;
      inband_cfg_r <= `RST_REG;
      lb_act_r     <= `RST_REG;
      lb_deact_r   <= `RST_REG;
      signalling_extractor_cfg_r   <= `RST_REG;
      tx_fmt_cfg_r <= `RST_REG;
      int_enable_r <= 4'h0;
    end else if (ce && wr_en) begin
      if (idx == `IDX_DL_OPTIONS) begin
        dl_options_r <= pwdata[7:0];
      end else if (idx == `IDX_RX_DEC_CFG) begin
        rx_dec_cfg_r <= pwdata[7:0];
      end else if (idx == `IDX_FRAMER_CFG) begin
        framer_cfg_r <= pwdata[7:0];
      end else if (idx == `IDX_BITCODE_EN) begin
        bitcode_en_r <= pwdata[7:0];
      end else if (idx == `IDX_ALARM_CFG) begin
        alarm_cfg_r <= pwdata[7:0];
      end else if (idx == `IDX_INBAND_CFG) begin
        inband_cfg_r <= pwdata[7:0];
      end else if (idx == `IDX_LB_ACT) begin
        lb_act_r <= pwdata[7:0];
      end else if (idx == `IDX_LB_DEACT) begin
        lb_deact_r <= pwdata[7:0];
      end else if (idx == `IDX_SIGNALLING_EXTRACTOR_CFG) begin
        signalling_extractor_cfg_r <= pwdata[7:0];
      end else if (idx == `IDX_TX_FMT_CFG) begin
        tx_fmt_cfg_r <= pwdata[7:0];
      end else if (idx == `IDX_INT_ENABLE) begin
        int_enable_r <= pwdata[3:0];
      end
    end
  end

  // decoded mode outputs, registered so pins come from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b8zs_rx_r   <= 1'b0;
      b8zs_tx_r   <= 1'b0;
      esf_all_r   <= 1'b0;
      oof_sel_r   <= 2'b00;
      boc_fast_r  <= 1'b0;
      inband_en_r <= 1'b0;
    end else if (ce) begin
      b8zs_rx_r  <= (rx_dec_cfg_r == 8'h00);
      // upper nibble 3 gives b8zs esf
      b8zs_tx_r  <= (tx_fmt_cfg_r[7:4] == `FMT_ESF_B8ZS);
      // esf select bit in the framer, alarm and signalling units
      esf_all_r  <= framer_cfg_r[`ESF_SEL_BIT] &
                    alarm_cfg_r[`ESF_SEL_BIT] &
                    signalling_extractor_cfg_r[`ESF_SEL_BIT];
      // 00 2of4, 01 2of5, 10 2of6
      oof_sel_r  <= framer_cfg_r[`OOF_HI:`OOF_LO];
      boc_fast_r <= bitcode_en_r[`BOC_FAST_BIT];
      inband_en_r <= (inband_cfg_r == 8'h00);
    end
  end

  // sticky status: set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_status_r       <= 4'h0;
      ev_prev_r          <= 4'h0;
      common_interrupt_n <= 1'b1;
      dma_req_rx_r       <= 1'b0;
      dma_req_tx_r       <= 1'b0;
    end else if (ce) begin
      ev_prev_r <= ev_lvl;
      if (dchan_mode) begin
        int_status_r <= (int_status_r & ~clr_mask) | ev_rise;
        dma_req_rx_r <= 1'b0;
        dma_req_tx_r <= 1'b0;
      end else begin
        int_status_r <= int_status_r & ~clr_mask;
        dma_req_rx_r <= ev_lvl[0] | ev_lvl[1];
        dma_req_tx_r <= ev_lvl[2] | ev_lvl[3];
      end
      // level is one cycle behind the status bit
      common_interrupt_n <= ~|(int_status_r & int_enable_r);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_dchannel_serial <= 1'b0;
      rx_dchannel_clock  <= 1'b0;
      tx_dchannel_clock  <= 1'b0;
      tx_dl_serial_out   <= 1'b0;
    end else if (ce) begin
      rx_dchannel_serial <= dchan_mode & rx_ser_s;
      rx_dchannel_clock  <= dchan_mode & rx_clk_s;
      // clock loops back the receive timing; no separate tx timing base
      tx_dchannel_clock  <= dchan_mode & rx_clk_s;
      tx_dl_serial_out   <= dchan_mode & tx_ser_s;
    end
  end
endmodule // dchan_setup

// >>> dv/dchan_setup_chk.sv
// assertion checker for the d-channel setup block, bound to its ports
// assumes ce stays high while apb transfers run
`timescale 1ns/1ps
module dchan_setup_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        rx_dchannel_serial,
  input wire        rx_dchannel_clock,
  input wire        tx_dchannel_clock,
  input wire        tx_dl_serial_out,
  input wire        dma_req_rx_r,
  input wire        dma_req_tx_r,
  input wire        b8zs_rx_r,
  input wire        b8zs_tx_r,
  input wire  [1:0] oof_sel_r,
  input wire        boc_fast_r,
  input wire        inband_en_r
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       tk = ce && psel && penable && !pready;
  wire [7:0] ix = paddr[9:2];
  wire       mp = ix inside {8'h02, 8'h08, 8'h09, 8'h10, 8'h20, 8'h2A,
    8'h2C, 8'h3C, 8'h3E, 8'h3F, 8'h40, 8'h44, 8'h50, 8'h51, 8'h52, 8'h53};
  // shadow of the datalink mode, kept from observed writes
  reg        on_r;
  always @(posedge pclk or negedge presetn)
    if (!presetn) on_r <= 1'b0;
    else if (tk && pwrite && ix == 8'h02) on_r <= pwdata[7:0] == 8'h5F;
  sequence s_wr(i); tk && pwrite && ix == i; endsequence
  sequence s_on; on_r && $past(on_r); endsequence
  property p_rdy; tk |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held");
  property p_err; tk |=> pslverr == !$past(mp); endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_rxd; s_wr(8'h10) |-> ##2 b8zs_rx_r == ($past(pwdata[7:0], 2) == 8'h00); endproperty
  a_rxd: assert property (p_rxd) else $error("rx coding wrong");
  property p_txf; s_wr(8'h44) |-> ##2 b8zs_tx_r == ($past(pwdata[7:4], 2) == 4'h3); endproperty
  a_txf: assert property (p_txf) else $error("tx coding wrong");
  property p_thr; s_wr(8'h20) |-> ##2 oof_sel_r == $past(pwdata[7:6], 2); endproperty
  a_thr: assert property (p_thr) else $error("threshold wrong");
  property p_boc; s_wr(8'h2A) |-> ##2 boc_fast_r == $past(pwdata[1], 2); endproperty
  a_boc: assert property (p_boc) else $error("validation wrong");
  property p_ibc; s_wr(8'h3C) |-> ##2 inband_en_r == ($past(pwdata[7:0], 2) == 8'h00); endproperty
  a_ibc: assert property (p_ibc) else $error("inband wrong");
  property p_dma; s_on |-> !dma_req_rx_r && !dma_req_tx_r; endproperty
  a_dma: assert property (p_dma) else $error("dma not folded");
  property p_off; !on_r && !$past(on_r) |-> !rx_dchannel_serial && !rx_dchannel_clock && !tx_dchannel_clock && !tx_dl_serial_out; endproperty
  a_off: assert property (p_off) else $error("pins not idle");
endmodule // dchan_setup_chk
bind dchan_setup dchan_setup_chk u_dchan_setup_chk (.pclk, .presetn, .ce,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .rx_dchannel_serial, .rx_dchannel_clock, .tx_dchannel_clock,
  .tx_dl_serial_out, .dma_req_rx_r, .dma_req_tx_r, .b8zs_rx_r, .b8zs_tx_r,
  .oof_sel_r, .boc_fast_r, .inband_en_r);

// >>> dv/dl_core_model.sv
// external hdlc core on the datalink pins: request lines and serial pins
// assumes the bench calls its tasks; all changes land on pclk edges
`timescale 1ns/1ps
module dl_core_model (
  input  wire pclk,
  input  wire tx_dchannel_clock,
  output wire rx_datalink_request,
  output wire rx_datalink_end_of_message,
  output wire tx_datalink_request,
  output wire tx_datalink_underrun,
  output wire rx_dl_serial_in,
  output wire rx_dl_clock_in,
  output wire tx_dchannel_serial
);
  reg [3:0] ev = 4'h0;
  reg       sl = 1'b0;
  integer   n_bits = 0;
  assign {tx_datalink_underrun, tx_datalink_request} = ev[3:2];
  assign {rx_datalink_end_of_message, rx_datalink_request} = ev[1:0];
  assign rx_dl_serial_in = sl;
  assign rx_dl_clock_in = sl;
  assign tx_dchannel_serial = sl;
  // any burst rate
  // no minimum spacing between clock edges is demanded
  always @(posedge tx_dchannel_clock) n_bits <= n_bits + 1;
  task set(input integer i, input v);
    @(posedge pclk) ev[i] <= v;
  endtask
  task line(input v);
    @(posedge pclk) sl <= v;
  endtask
endmodule // dl_core_model

// >>> dv/tb.sv
// self-checking bench for the d-channel setup block
// assumes ce held high; far side is dl_core_model
`timescale 1ns/1ps
module tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         ce = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] paddr = 32'h0;
  reg  [31:0] pwdata = 32'h0;
  reg  [31:0] q;
  reg         e;
  reg  [7:0]  x, f;
  wire [31:0] prdata;
  wire [1:0]  oof_sel_r;
  wire pready, pslverr, rx_datalink_request, rx_datalink_end_of_message,
    tx_datalink_request, tx_datalink_underrun, rx_dl_serial_in,
    rx_dl_clock_in, tx_dl_serial_out, rx_dchannel_serial, rx_dchannel_clock,
    tx_dchannel_serial, tx_dchannel_clock, dma_req_rx_r, dma_req_tx_r,
    b8zs_rx_r, b8zs_tx_r, esf_all_r, boc_fast_r, inband_en_r,
    common_interrupt_n;
  integer n_fail = 0, n_tests = 0, seed = 98949, i, k;
  always #12.5 pclk = ~pclk;
  dchan_setup u_dchan_setup (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_datalink_request,
    .rx_datalink_end_of_message, .tx_datalink_request, .tx_datalink_underrun,
    .rx_dl_serial_in, .rx_dl_clock_in, .tx_dl_serial_out, .rx_dchannel_serial,
    .rx_dchannel_clock, .tx_dchannel_serial, .tx_dchannel_clock, .dma_req_rx_r,
    .dma_req_tx_r, .b8zs_rx_r, .b8zs_tx_r, .esf_all_r, .oof_sel_r, .boc_fast_r,
    .inband_en_r, .common_interrupt_n);
  dl_core_model u_dl_core_model (.pclk, .tx_dchannel_clock, .rx_datalink_request,
    .rx_datalink_end_of_message, .tx_datalink_request, .tx_datalink_underrun,
    .rx_dl_serial_in, .rx_dl_clock_in, .tx_dchannel_serial);
  task test_done;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] ex, input [31:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== ex) begin
        n_fail = n_fail + 1;
        $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
    end
  endtask
  task apb(input w, input [7:0] ix, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= {22'h0, ix, 2'b00}; pwdata <= d;
      @(posedge pclk) penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin k = k + 1; @(posedge pclk); end
      q = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (k == 20) begin chk("pready", 1, 0); test_done; end
    end
  endtask
  task wr(input [7:0] ix, input [7:0] d); apb(1, ix, {24'h0, d}); endtask
  task rd(input [7:0] ix, input [7:0] ex);
    begin apb(0, ix, 32'h0); chk("prdata", {24'h0, ex}, q); end
  endtask
  task wint(input v);
    begin
      k = 0;
      while (common_interrupt_n !== v && k < 50) begin k = k + 1; @(posedge pclk); end
      chk("common_interrupt_n", v, common_interrupt_n);
      if (k == 50) test_done;
    end
  endtask
  function [7:0] map_ix(input integer n);
    case (n)
      0: map_ix = 8'h02;  1: map_ix = 8'h08;  2: map_ix = 8'h09;
      3: map_ix = 8'h10;  4: map_ix = 8'h20;  5: map_ix = 8'h2A;
      6: map_ix = 8'h2C;  7: map_ix = 8'h3C;  8: map_ix = 8'h3E;
      9: map_ix = 8'h3F; 10: map_ix = 8'h40; 11: map_ix = 8'h44;
      default: map_ix = 8'h44 + n;
    endcase
  endfunction
  function [7:0] rst_val(input [7:0] ix);
    rst_val = (ix == 8'h10 || ix == 8'h53) ? 8'h01 : 8'h00;
  endfunction
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      x = map_ix(i);
      rd(x, rst_val(x));
    end
    chk("b8zs_rx_r", 0, b8zs_rx_r);
    $display("reset values done");
    for (i = 0; i < 3; i = i + 1) begin
      x = $random(seed) & 8'h0F;
      f = {i[1:0], 2'b01, x[3:0]};
      wr(8'h10, 8'h00); wr(8'h44, 8'h30 | x); wr(8'h20, f);
      wr(8'h2A, (i == 1) ? 8'h02 : 8'h00); wr(8'h2C, 8'h10 | x);
      wr(8'h3C, 8'h00); wr(8'h3E, 8'h08); wr(8'h3F, 8'h44);
      wr(8'h40, 8'h10 | x); wr(8'h02, 8'h5F);
      chk("b8zs", 3, {b8zs_rx_r, b8zs_tx_r});
      chk("esf_all_r", 1, esf_all_r);
      chk("oof_sel_r", f[7:6], oof_sel_r);
      chk("boc_fast_r", i == 1, boc_fast_r);
      chk("inband_en_r", 1, inband_en_r);
      rd(8'h53, 8'h03); rd(8'h20, f); rd(8'h3E, 8'h08); rd(8'h3F, 8'h44);
    end
    wr(8'h44, 8'h30 | (x ^ 8'h01)); rd(8'h53, 8'h02);
    wr(8'h10, 8'h01); @(posedge pclk);
    chk("b8zs_rx_r", 0, b8zs_rx_r);
    apb(1, 8'h55, 32'hFF); chk("pslverr", 1, e); rd(8'h55, 8'h00); rd(8'h52, 8'h00);
    $display("config done");
    u_dl_core_model.line(1); repeat (8) @(posedge pclk);
    chk("dchannel pins", 4'hF, {rx_dchannel_serial, rx_dchannel_clock,
      tx_dchannel_clock, tx_dl_serial_out});
    chk("tx clock edges", 1, u_dl_core_model.n_bits > 0);
    wr(8'h02, 8'h00); repeat (8) @(posedge pclk);
    chk("dchannel pins", 4'h0, {rx_dchannel_serial, rx_dchannel_clock,
      tx_dchannel_clock, tx_dl_serial_out});
    u_dl_core_model.line(0);
    u_dl_core_model.set(0, 1); u_dl_core_model.set(2, 1); repeat (8) @(posedge pclk);
    chk("dma_req", 3, {dma_req_rx_r, dma_req_tx_r});
    u_dl_core_model.set(0, 0); u_dl_core_model.set(2, 0); rd(8'h50, 8'h00);
    $display("routing done");
    wr(8'h02, 8'h5F); wr(8'h51, 8'h0F); rd(8'h51, 8'h0F);
    for (i = 0; i < 4; i = i + 1) begin
      u_dl_core_model.set(i, 1); repeat (8) @(posedge pclk); u_dl_core_model.set(i, 0);
      wint(0); rd(8'h50, 8'h01 << i);
      rd(8'h08, (8'h01 << i) & 8'h03); rd(8'h09, (8'h01 << i) >> 2);
      wr(8'h52, 8'h01 << i); wint(1); rd(8'h50, 8'h00);
    end
    wr(8'h51, 8'h0E); u_dl_core_model.set(0, 1); repeat (12) @(posedge pclk);
    u_dl_core_model.set(0, 0); chk("common_interrupt_n", 1, common_interrupt_n);
    rd(8'h50, 8'h01); wr(8'h51, 8'h0F); wint(0); wr(8'h52, 8'h01); wint(1);
    $display("interrupts done");
    @(posedge pclk) presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h02, 8'h00); rd(8'h10, 8'h01); chk("common_interrupt_n", 1, common_interrupt_n);
    $display("second reset done");
    test_done;
  end
endmodule // tb
